// file: core/iah_pkg.sv
`default_nettype none

package iah_pkg;

    // ----------------------------------------------------------------
    // Widths and counts
    // ----------------------------------------------------------------
    localparam int NUM_DIRS = 2;
    localparam int NUM_BINS = 8;
    localparam int NUM_PROFILES = 2;
    localparam int IAT_W = 16;
    localparam int DIR_US = 0;
    localparam int DIR_DS = 1;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] CFG_BASE = 8'h10;
    localparam logic [7:0] CFG_END = 8'h1C;
    localparam logic [7:0] BIN_BASE = 8'h40;
    localparam logic [7:0] BIN_END = 8'h7C;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_THR_LSB = 0;
    localparam int CTRL_PROF_BIT = 8;
    localparam int STAT_REJ_BIT = 0;
    localparam int STAT_CLU_LSB = 1;
    localparam int CFG_OFF_LSB = 0;
    localparam int CFG_STEP_LSB = 12;
    localparam int CFG_GAP_LSB = 16;
    localparam int CFG_MODE_LSB = 24;
    localparam logic [31:0] CFG_MASK = 32'h037F_F1FF;

    // ----------------------------------------------------------------
    // Legal ranges
    // ----------------------------------------------------------------
    localparam logic [8:0] OFF_MIN = 9'h003;
    localparam logic [8:0] OFF_MAX = 9'h1FF;
    localparam logic [3:0] STEP_MAX = 4'h7;
    localparam logic [6:0] GAP_MAX = 7'h40;
    localparam logic [IAT_W-1:0] MID_BINS = 16'h0006;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CFG_RST = 32'h0000_0003;

endpackage : iah_pkg

`default_nettype wire

// file: core/iah_evt_if.sv
`timescale 1ns/10ps
`default_nettype none

interface iah_evt_if;
    import iah_pkg::*;
    logic start;
    logic [IAT_W-1:0] iat;

    modport src (output start, output iat);
    modport dst (input start, input iat);
endinterface : iah_evt_if

`default_nettype wire

// file: core/iah_cluster.sv
`timescale 1ns/10ps
`default_nettype none

module iah_cluster (
    input wire logic ref_clk, // Symbol-rate clock.
    input wire logic sys_rst, // Asynchronous reset, active high.
    input wire logic sym_valid, // One data symbol this cycle.
    input wire logic signed [7:0] sym_metric, // Impulse metric, 0.1 dB.
    input wire logic signed [7:0] threshold, // Degraded threshold.
    input wire logic [6:0] gap_limit, // Cluster gap limit.
    input wire logic [1:0] eq_mode, // Protection mode.
    output logic in_cluster, // A cluster is open.
    iah_evt_if.src ev // Cluster start events.
);
    import iah_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_OPEN = 2'b10
    } iah_clu_state_type;

    iah_clu_state_type state_reg, state_next;
    logic [6:0] gap_reg, gap_next;
    logic [IAT_W-1:0] since_reg, since_next;
    logic seen_reg, seen_next;
    logic start_reg, start_next;
    logic [IAT_W-1:0] iat_reg, iat_next;
    logic degraded;
    logic [6:0] eff_limit;
    logic [IAT_W-1:0] since_inc;

    assign degraded = sym_metric >= threshold; // R8
    // Mode zero treats every burst as its own event.
    assign eff_limit = (eq_mode == 2'h0) ? 7'h00 : gap_limit; // R11
    assign since_inc = (since_reg == {IAT_W{1'b1}}) ? since_reg
                                                    : since_reg + 1'b1;

    always_comb
    begin
        state_next = state_reg;
        gap_next = gap_reg;
        since_next = since_reg;
        seen_next = seen_reg;
        start_next = 1'b0;
        iat_next = iat_reg;
        if (sym_valid)
        begin
            since_next = since_inc; // R10
            case (state_reg)
                ST_IDLE:
                begin
                    if (degraded)
                    begin
                        // The first cluster has no predecessor to measure.
                        start_next = seen_reg;
                        iat_next = since_inc; // R10
                        since_next = '0;
                        seen_next = 1'b1;
                        gap_next = '0;
                        state_next = ST_OPEN;
                    end
                end
                ST_OPEN:
                begin
                    if (degraded)
                    begin
                        gap_next = '0;
                    end
                    else if (gap_reg >= eff_limit)
                    begin
                        state_next = ST_IDLE; // R11
                    end
                    else
                    begin
                        gap_next = gap_reg + 1'b1;
                    end
                end
                default:
                begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_IDLE;
            gap_reg <= '0;
            since_reg <= '0;
            seen_reg <= 1'b0;
            start_reg <= 1'b0;
            iat_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            gap_reg <= gap_next;
            since_reg <= since_next;
            seen_reg <= seen_next;
            start_reg <= start_next;
            iat_reg <= iat_next;
        end
    end

    assign in_cluster = (state_reg == ST_OPEN);
    assign ev.start = start_reg;
    assign ev.iat = iat_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_new_burst;
        sym_valid && degraded && (state_reg == ST_IDLE) && seen_reg;
    endsequence

    a_degraded_start: assert property ( // R8
        @(posedge ref_clk) disable iff (sys_rst)
        s_new_burst |=> start_reg && (iat_reg == $past(since_inc)))
        else $error("Degraded symbol did not open a cluster");

    a_gap_close: assert property ( // R11
        @(posedge ref_clk) disable iff (sys_rst)
        sym_valid && !degraded && (state_reg == ST_OPEN)
        && (gap_reg >= eff_limit) |=> state_reg == ST_IDLE)
        else $error("Cluster stayed open past the gap limit");

    a_gap_hold: assert property ( // R11
        @(posedge ref_clk) disable iff (sys_rst)
        sym_valid && !degraded && (state_reg == ST_OPEN)
        && (gap_reg < eff_limit) |=> state_reg == ST_OPEN)
        else $error("Cluster closed on a short gap");

endmodule : iah_cluster

`default_nettype wire

// file: core/iah_top.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// [R1] Offset writes accepted only from 3 to 511.
// [R2] Eight histogram bins per direction.
// [R3] Bins 1-6 cover consecutive power-of-two slices.
// [R4] Values below offset go to bin 0.
// [R5] Values past six slices go to bin 7.
// [R6] Step exponent writes accepted only 0 to 7.
// [R7] Threshold held in 0.1 dB, -12.8..+12.7.
// [R8] Lower threshold flags degraded symbols more often.
// [R9] Separate upstream/downstream settings per profile.
// [R10] Interval counts symbols between cluster starts.
// [R11] Cluster ends when gap exceeds limit 0..64.
// [R12] Bins are saturating counters cleared by reset.
// [R13] Classification and count take fixed cycles.

module iah_top #(
    parameter int CNT_W = 32 // Width of each histogram counter.
) (
    input wire logic ref_clk, // 250 MHz clock.
    input wire logic sys_rst, // Asynchronous reset, active high.
    input wire logic [7:0] avs_address, // Byte address, word aligned.
    input wire logic avs_read, // Read request.
    input wire logic avs_write, // Write request.
    input wire logic [31:0] avs_writedata, // Write data.
    output logic [31:0] avs_readdata, // Read data.
    output logic avs_waitrequest, // Stall, active high.
    input wire logic [iah_pkg::NUM_DIRS-1:0] sym_valid, // Symbol strobes.
    input wire logic [15:0] sym_metric // Two signed metrics, us low.
);
    import iah_pkg::*;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [31:0] ctrl_reg, ctrl_next;
    logic rej_reg, rej_next;
    logic [31:0] cfg_reg [NUM_PROFILES][NUM_DIRS];
    logic [31:0] cfg_next [NUM_PROFILES][NUM_DIRS];
    logic [31:0] rdata_reg, rdata_next;
    logic wait_reg, wait_next;
    logic acc_done;
    logic [31:0] rd_mux;
    logic cfg_hit;
    logic cfg_p;
    logic cfg_d;
    logic wr_ok;

    // ----------------------------------------------------------------
    // Datapath state
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] bin_reg [NUM_DIRS][NUM_BINS];
    logic [CNT_W-1:0] bin_next [NUM_DIRS][NUM_BINS];
    logic [NUM_DIRS-1:0] pend_reg, pend_next;
    logic [2:0] pbin_reg [NUM_DIRS];
    logic [2:0] pbin_next [NUM_DIRS];
    logic [31:0] act_cfg [NUM_DIRS];
    logic [NUM_DIRS-1:0] clu_open;
    logic [NUM_DIRS-1:0] ev_start;
    logic [IAT_W-1:0] ev_iat [NUM_DIRS];

    iah_evt_if ev [NUM_DIRS] ();

    function automatic logic cfg_valid(input logic [31:0] w);
        logic [8:0] off;
        logic [3:0] st;
        logic [6:0] gap;
        off = w[CFG_OFF_LSB +: 9];
        st = w[CFG_STEP_LSB +: 4];
        gap = w[CFG_GAP_LSB +: 7];
        return (off >= OFF_MIN) && (off <= OFF_MAX) // R1
            && (st <= STEP_MAX) // R6
            && (gap <= GAP_MAX); // R11
    endfunction : cfg_valid

    function automatic logic [2:0] bin_of(input logic [IAT_W-1:0] iat,
                                          input logic [8:0] off,
                                          input logic [2:0] st);
        logic [IAT_W-1:0] off_w;
        logic [IAT_W-1:0] slot;
        off_w = {{(IAT_W-9){1'b0}}, off};
        slot = (iat - off_w) >> st;
        if (iat < off_w)
            return 3'h0; // R4
        if (slot >= MID_BINS)
            return 3'h7; // R5
        return slot[2:0] + 3'h1; // R3
    endfunction : bin_of

    // ----------------------------------------------------------------
    // Cluster trackers, one per direction
    // ----------------------------------------------------------------
    for (genvar g = 0; g < NUM_DIRS; g++)
    begin : g_dir
        assign act_cfg[g] = cfg_reg[ctrl_reg[CTRL_PROF_BIT]][g]; // R9
        iah_cluster u_clu (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .sym_valid(sym_valid[g]),
            .sym_metric(sym_metric[8*g +: 8]),
            .threshold(ctrl_reg[CTRL_THR_LSB +: 8]), // R7
            .gap_limit(act_cfg[g][CFG_GAP_LSB +: 7]),
            .eq_mode(act_cfg[g][CFG_MODE_LSB +: 2]),
            .in_cluster(clu_open[g]),
            .ev(ev[g])
        );
        assign ev_start[g] = ev[g].start;
        assign ev_iat[g] = ev[g].iat;
    end

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    // Every access waits exactly one cycle so read data can be registered.
    assign acc_done = (avs_read || avs_write) && !wait_reg;
    assign cfg_hit = (avs_address >= CFG_BASE) && (avs_address <= CFG_END);
    // Inside the config window the profile is the eight-byte pair index.
    assign cfg_p = avs_address[3];
    assign cfg_d = avs_address[2];
    assign wr_ok = cfg_valid(avs_writedata);

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (avs_address[1:0] == 2'h0)
        begin
            if (avs_address == CTRL_OFS)
                rd_mux = ctrl_reg;
            else if (avs_address == STATUS_OFS)
                rd_mux = {29'h0, clu_open, rej_reg};
            else if (cfg_hit)
                rd_mux = cfg_reg[cfg_p][cfg_d];
            else if (avs_address >= BIN_BASE && avs_address <= BIN_END)
                rd_mux = 32'(bin_reg[avs_address[5]][avs_address[4:2]]);
        end
    end

    always_comb
    begin
        wait_next = !((avs_read || avs_write) && wait_reg);
        rdata_next = (avs_read && wait_reg) ? rd_mux : rdata_reg;
        ctrl_next = ctrl_reg;
        rej_next = rej_reg;
        cfg_next = cfg_reg;
        if (acc_done && avs_write)
        begin
            if (avs_address == CTRL_OFS)
                ctrl_next = avs_writedata & 32'h0000_01FF;
            else if (avs_address == STATUS_OFS
                     && avs_writedata[STAT_REJ_BIT])
                rej_next = 1'b0;
            else if (cfg_hit && avs_address[1:0] == 2'h0)
            begin
                if (wr_ok)
                    cfg_next[cfg_p][cfg_d] = avs_writedata & CFG_MASK;
                else
                    rej_next = 1'b1; // R1
            end
        end
        // An out-of-range word at an unaligned config address is not stored but still sets the flag.
        if (acc_done && avs_write && cfg_hit && !wr_ok)
            rej_next = 1'b1; // R6
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_reg <= CTRL_RST;
            rej_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            wait_reg <= 1'b1;
            for (int p = 0; p < NUM_PROFILES; p++)
                for (int d = 0; d < NUM_DIRS; d++)
                    cfg_reg[p][d] <= CFG_RST; // R9
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            rej_reg <= rej_next;
            rdata_reg <= rdata_next;
            wait_reg <= wait_next;
            cfg_reg <= cfg_next;
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;

    // ----------------------------------------------------------------
    // Classifier and histogram
    // ----------------------------------------------------------------
    always_comb
    begin
        bin_next = bin_reg;
        for (int d = 0; d < NUM_DIRS; d++)
        begin
            pend_next[d] = ev_start[d]; // R13
            pbin_next[d] = bin_of(ev_iat[d],
                                  act_cfg[d][CFG_OFF_LSB +: 9],
                                  act_cfg[d][CFG_STEP_LSB +: 3]);
            if (pend_reg[d] && bin_reg[d][pbin_reg[d]] != {CNT_W{1'b1}})
                bin_next[d][pbin_reg[d]] =
                    bin_reg[d][pbin_reg[d]] + 1'b1; // R12
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pend_reg <= '0;
            for (int d = 0; d < NUM_DIRS; d++)
            begin
                pbin_reg[d] <= 3'h0;
                for (int b = 0; b < NUM_BINS; b++)
                    bin_reg[d][b] <= '0; // R2
            end
        end
        else
        begin
            pend_reg <= pend_next;
            pbin_reg <= pbin_next;
            bin_reg <= bin_next;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [IAT_W-1:0] us_off;
    logic [IAT_W-1:0] us_span;
    assign us_off = {{(IAT_W-9){1'b0}}, act_cfg[0][CFG_OFF_LSB +: 9]};
    assign us_span = IAT_W'(1) << act_cfg[0][CFG_STEP_LSB +: 3];

    sequence s_us_event;
        ev_start[0] && !pend_reg[0];
    endsequence

    a_offset_floor: assert property ( // R1
        @(posedge ref_clk) disable iff (sys_rst)
        act_cfg[0][CFG_OFF_LSB +: 9] >= OFF_MIN
        && act_cfg[1][CFG_OFF_LSB +: 9] >= OFF_MIN)
        else $error("Stored offset below minimum");

    a_bad_write_kept: assert property ( // R6
        @(posedge ref_clk) disable iff (sys_rst)
        acc_done && avs_write && cfg_hit && !wr_ok
        |=> $stable(act_cfg[0]) && $stable(act_cfg[1]) && rej_reg)
        else $error("Out of range setting was stored");

    a_bin_low: assert property ( // R4
        @(posedge ref_clk) disable iff (sys_rst)
        ev_start[0] && ev_iat[0] < us_off
        && $stable(act_cfg[0]) |=> pbin_reg[0] == 3'h0)
        else $error("Short interval not in bin 0");

    a_bin_high: assert property ( // R5
        @(posedge ref_clk) disable iff (sys_rst)
        ev_start[0] && ev_iat[0] >= us_off + us_span * 6
        |=> pbin_reg[0] == 3'h7)
        else $error("Long interval not in bin 7");

    a_bin_first: assert property ( // R3
        @(posedge ref_clk) disable iff (sys_rst)
        ev_start[0] && ev_iat[0] >= us_off
        && ev_iat[0] < us_off + us_span |=> pbin_reg[0] == 3'h1)
        else $error("First slice not in bin 1");

    a_bin_six: assert property ( // R3
        @(posedge ref_clk) disable iff (sys_rst)
        ev_start[0] && ev_iat[0] >= us_off + us_span * 5
        && ev_iat[0] < us_off + us_span * 6 |=> pbin_reg[0] == 3'h6)
        else $error("Sixth slice not in bin 6");

    a_count_step: assert property ( // R13
        @(posedge ref_clk) disable iff (sys_rst)
        s_us_event ##1 (bin_reg[0][pbin_reg[0]] != {CNT_W{1'b1}})
        |=> bin_reg[0][$past(pbin_reg[0])]
            == $past(bin_reg[0][pbin_reg[0]]) + 1'b1)
        else $error("Bin not incremented two cycles after event");

    a_count_sat: assert property ( // R12
        @(posedge ref_clk) disable iff (sys_rst)
        pend_reg[0] && bin_reg[0][pbin_reg[0]] == {CNT_W{1'b1}}
        |=> bin_reg[0][$past(pbin_reg[0])] == {CNT_W{1'b1}})
        else $error("Saturated bin wrapped");

    a_ds_count: assert property ( // R12
        @(posedge ref_clk) disable iff (sys_rst)
        pend_reg[1] && bin_reg[1][pbin_reg[1]] != {CNT_W{1'b1}}
        |=> bin_reg[1][$past(pbin_reg[1])]
            == $past(bin_reg[1][pbin_reg[1]]) + 1'b1)
        else $error("Downstream bin not incremented");

    // A stored step above seven would lose its top bit in the classifier.
    a_cfg_ranges: assert property ( // R6 R11
        @(posedge ref_clk) disable iff (sys_rst)
        act_cfg[0][CFG_STEP_LSB +: 4] <= STEP_MAX
        && act_cfg[1][CFG_STEP_LSB +: 4] <= STEP_MAX
        && act_cfg[0][CFG_GAP_LSB +: 7] <= GAP_MAX
        && act_cfg[1][CFG_GAP_LSB +: 7] <= GAP_MAX)
        else $error("Stored step or gap out of range");

    a_bus_wait: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (avs_read || avs_write) && wait_reg |=> !wait_reg ##1 wait_reg)
        else $error("Waitrequest did not drop for exactly one cycle");

    a_rdata_hold: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !(avs_read && wait_reg) |=> $stable(avs_readdata))
        else $error("Read data changed without a read");

endmodule : iah_top

`default_nettype wire

// file: dv/iah_sym_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Symbol source standing in for the transceiver impulse detector
// ----------------------------------------------------------------
module iah_sym_model (
    input wire logic ref_clk, // Symbol-rate clock.
    output logic [1:0] sym_valid, // Symbol strobes, us bit 0.
    output logic [15:0] sym_metric // Two signed metrics, us low.
);
    initial
    begin
        sym_valid = 2'h0;
        sym_metric = 16'h0000;
    end

    // Sends n back-to-back symbols of one metric, then goes idle.
    // Between symbols the metric shows the inverse of its last value, so
    // a design that samples it without a strobe sees wrong data.
    task automatic send(input int dir, input logic [7:0] m, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk);
            sym_valid <= 2'h1 << dir;
            sym_metric <= (dir == 0) ? {~m, m} : {m, ~m};
        end
        @(posedge ref_clk);
        sym_valid <= 2'h0;
        sym_metric <= ~sym_metric;
    endtask : send
endmodule : iah_sym_model

`default_nettype wire

// file: dv/iah_top_test.sv
`timescale 1ns/10ps
`default_nettype none

module iah_top_test;
    import iah_pkg::*;
    localparam int CW = 4;
    localparam logic [7:0] DEG = 8'h0A;
    localparam logic [7:0] CLN = 8'hF6;
    logic ref_clk;
    logic sys_rst;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] sym_valid;
    logic [15:0] sym_metric;
    logic [31:0] rd;
    logic [31:0] exp_bin [2][8];
    int fails;
    int n_checks;
    // Columns: direction, offset, step, interval, expected bin.
    int rows [13][5] = '{'{0, 3, 0, 3, 1}, '{0, 3, 0, 8, 6},
        '{0, 3, 0, 9, 7}, '{0, 8, 2, 7, 0}, '{0, 8, 2, 8, 1},
        '{0, 8, 2, 11, 1}, '{0, 8, 2, 12, 2}, '{0, 8, 2, 31, 6},
        '{0, 8, 2, 32, 7}, '{1, 511, 7, 510, 0}, '{1, 511, 7, 511, 1},
        '{1, 3, 7, 131, 2}, '{1, 3, 7, 130, 1}};
    logic [31:0] bad [3] = '{32'h0000_0002, 32'h0000_8005, 32'h0041_0005};

    iah_top #(.CNT_W(CW)) DUT (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .sym_valid(sym_valid),
        .sym_metric(sym_metric)
    );

    iah_sym_model SRC (
        .ref_clk(ref_clk),
        .sym_valid(sym_valid),
        .sym_metric(sym_metric)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Holds the request until waitrequest is sampled low at a rising edge.
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [31:0] wd);
        int guard;
        guard = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= we;
        avs_read <= ~we;
        avs_writedata <= wd;
        do
        begin
            @(posedge ref_clk);
            guard++;
        end
        while (avs_waitrequest !== 1'b0 && guard < 50);
        rd = avs_readdata;
        if (guard >= 50)
            fails++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(what, rd, exp);
    endtask : rd_chk

    // Cluster start, then iat-1 clean symbols ahead of the next start.
    task automatic interval(input int d, input int iat, input int b);
        SRC.send(d, CLN, iat - 1);
        SRC.send(d, DEG, 1);
        repeat (4) @(posedge ref_clk);
        if (exp_bin[d][b] < 32'((1 << CW) - 1))
            exp_bin[d][b] += 32'h1;
    endtask : interval

    task automatic all_bins;
        for (int d = 0; d < 2; d++)
            for (int b = 0; b < 8; b++)
                rd_chk("bin", BIN_BASE + 8'(32 * d + 4 * b),
                       exp_bin[d][b]);
    endtask : all_bins

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        complete_run();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        fails = 0;
        n_checks = 0;
        exp_bin = '{default: 32'h0};
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        SRC.send(0, DEG, 1);
        SRC.send(1, DEG, 1);
        foreach (rows[r])
        begin
            bus(1'b1, CFG_BASE + 8'(4 * rows[r][0]),
                32'(rows[r][1]) | (32'(rows[r][2]) << 12));
            interval(rows[r][0], rows[r][3], rows[r][4]);
            rd_chk("row bin", BIN_BASE + 8'(32 * rows[r][0] + 4 * rows[r][4]),
                   exp_bin[rows[r][0]][rows[r][4]]);
        end
        all_bins();
        SRC.send(0, CLN, 1);
        SRC.send(1, CLN, 1);
        // Out-of-range words are dropped whole and flagged.
        foreach (bad[i])
        begin
            bus(1'b1, CFG_BASE, bad[i]);
            rd_chk("cfg kept", CFG_BASE, 32'h0000_2008);
            rd_chk("reject flag", STATUS_OFS, 32'h0000_0001);
            bus(1'b1, STATUS_OFS, 32'h0000_0001);
        end
        bus(1'b1, CFG_BASE, 32'h0340_7003);
        rd_chk("cfg edge", CFG_BASE, 32'h0340_7003);
        bus(1'b1, CFG_BASE, 32'hFC80_0FFF);
        rd_chk("cfg mask", CFG_BASE, 32'hFC80_0FFF & CFG_MASK);
        rd_chk("no reject", STATUS_OFS, 32'h0000_0000);
        rd_chk("unmapped", 8'h08, 32'h0000_0000);
        bus(1'b1, 8'h08, 32'hFFFF_FFFF);
        rd_chk("unaligned", 8'h41, 32'h0000_0000);
        bus(1'b1, BIN_BASE, 32'h0000_000F);
        rd_chk("bin ro", BIN_BASE, exp_bin[0][0]);
        // Threshold sensitivity and cluster gap limit.
        bus(1'b1, CFG_BASE, 32'h0102_0003);
        bus(1'b1, CTRL_OFS, 32'h0000_0014);
        SRC.send(0, DEG, 1);
        rd_chk("high thr", STATUS_OFS, 32'h0000_0000);
        bus(1'b1, CTRL_OFS, 32'h0000_0080);
        rd_chk("thr", CTRL_OFS, 32'h0000_0080);
        SRC.send(0, 8'h80, 1);
        rd_chk("low thr", STATUS_OFS, 32'h0000_0002);
        bus(1'b1, CTRL_OFS, 32'h0000_0000);
        SRC.send(0, CLN, 2);
        rd_chk("gap open", STATUS_OFS, 32'h0000_0002);
        SRC.send(0, CLN, 1);
        rd_chk("gap closed", STATUS_OFS, 32'h0000_0000);
        // Mid-run reset clears counters and settings.
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        exp_bin = '{default: 32'h0};
        rd_chk("ctrl rst", CTRL_OFS, CTRL_RST);
        rd_chk("stat rst", STATUS_OFS, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
            rd_chk("cfg rst", CFG_BASE + 8'(4 * i), CFG_RST);
        all_bins();
        // Profile one carries its own upstream offset.
        bus(1'b1, CFG_BASE + 8'h08, 32'h0000_0014);
        bus(1'b1, CTRL_OFS, 32'h0000_0100);
        SRC.send(0, DEG, 1);
        interval(0, 20, 1);
        rd_chk("profile", BIN_BASE + 8'h04, exp_bin[0][1]);
        // Counters stop at all ones.
        repeat (17) interval(0, 20, 1);
        rd_chk("saturate", BIN_BASE + 8'h04, 32'h0000_000F);
        all_bins();
        complete_run();
    end
endmodule : iah_top_test

`default_nettype wire
